// File: pkg/spam_pkg.sv
package spam_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_PIPES = 6;
  localparam int ADDR_BYTES_MAX = 5;
  localparam int ADDR_W = 8 * ADDR_BYTES_MAX;
  localparam int PIPE_IDX_W = 3;
  localparam int BYTE_W = 8;
  localparam int FIRST_LOW_PIPE = 2;

  // ****************************************************************
  // address width codes and reset values
  // ****************************************************************
  localparam logic [1:0] AW_3BYTE = 2'h1;
  localparam logic [1:0] AW_4BYTE = 2'h2;
  localparam logic [1:0] AW_5BYTE = 2'h3;
  localparam logic [1:0] AW_RESET = 2'h3;
  localparam logic [1:0] AW_INVALID = 2'h0;
  localparam logic [39:0] MASK_3BYTE = 40'h00_00FF_FFFF;
  localparam logic [39:0] MASK_4BYTE = 40'h00_FFFF_FFFF;
  localparam logic [39:0] MASK_5BYTE = 40'hFF_FFFF_FFFF;
  localparam logic [5:0] PIPE_EN_RESET = 6'h03;
  localparam logic [39:0] PIPE0_ADDR_RESET = 40'hE7_E7E7_E7E7;
  localparam logic [39:0] PIPE1_ADDR_RESET = 40'hC2_C2C2_C2C2;
  localparam logic [7:0] LOW_BYTE_BASE = 8'hC3;
  localparam logic [PIPE_IDX_W-1:0] PIPE_NONE = 3'h7;

  // ****************************************************************
  // configuration write selectors
  // ****************************************************************
  typedef enum logic [2:0] {
    SPAM_WR_NONE,
    SPAM_WR_PIPE0,
    SPAM_WR_PIPE1,
    SPAM_WR_LOWBYTE,
    SPAM_WR_ENABLE,
    SPAM_WR_WIDTH
  } spam_wr_t;
endpackage

// File: pkg/spam_match_if.sv
`timescale 1ns/100ps
interface spam_match_if;
  import spam_pkg::*;
  logic [ADDR_W-1:0] rxAddr;
  logic [1:0] addrWidth;
  logic [ADDR_W-1:0] pipe0Addr;
  logic [ADDR_W-1:0] pipe1Addr;
  logic [NUM_PIPES*8-1:0] lowBytes;
  logic [NUM_PIPES-1:0] pipeEn;
  logic hit;
  logic [PIPE_IDX_W-1:0] hitPipe;

  modport top (output rxAddr, addrWidth, pipe0Addr, pipe1Addr, lowBytes, pipeEn, input hit, hitPipe);
  modport cmp (input rxAddr, addrWidth, pipe0Addr, pipe1Addr, lowBytes, pipeEn, output hit, hitPipe);
endinterface

// File: logic/spam_comparator.sv
`timescale 1ns/100ps
module spam_comparator
  import spam_pkg::*;
(
  spam_match_if.cmp mif
);
  // ****************************************************************
  // width mask, common for every pipe
  // ****************************************************************
  wire [ADDR_W-1:0] widthMask = (mif.addrWidth == AW_3BYTE) ? MASK_3BYTE :
                                (mif.addrWidth == AW_4BYTE) ? MASK_4BYTE : MASK_5BYTE;
  wire [NUM_PIPES-1:0] pipeHit;

  // ****************************************************************
  // per-pipe compare
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PIPES; gi = gi + 1) begin : g_pipe
      wire [ADDR_W-1:0] pipeAddr;
      if (gi == 0) begin : g_p0
        assign pipeAddr = mif.pipe0Addr;
      end else begin : g_pn
        // pipes 1..5 share bytes 1..4 of pipe 1
        assign pipeAddr = {mif.pipe1Addr[ADDR_W-1:BYTE_W], mif.lowBytes[gi*BYTE_W +: BYTE_W]};
      end
      assign pipeHit[gi] = mif.pipeEn[gi] && (((pipeAddr ^ mif.rxAddr) & widthMask) == '0);
    end
  endgenerate

  // ****************************************************************
  // lowest matching pipe wins
  // ****************************************************************
  always_comb begin
    mif.hitPipe = PIPE_NONE;
    for (int i = NUM_PIPES - 1; i >= 0; i--) begin
      if (pipeHit[i]) begin
        mif.hitPipe = PIPE_IDX_W'(i);
      end
    end
  end
  assign mif.hit = |pipeHit;
endmodule

// File: logic/spam_address_match.sv
`timescale 1ns/100ps
// Functional notes
// - receiver accepts up to six pipes
// - one address width, three to five bytes
// - per-pipe enable, pipes 0 and 1 default
// - pipe 0 and 1 loaded by separate writes
// - pipes 1..5 share bytes 1..4
// - store sender address for acknowledgement
module spam_address_match
  import spam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration writes from command decoder
  input wire logic cfgWrite,
  input wire spam_wr_t cfgSel,
  input wire logic [PIPE_IDX_W-1:0] cfgPipe,
  input wire logic [ADDR_W-1:0] cfgData,
  // receive side
  input wire logic rxValid,
  input wire logic rxPayloadOk,
  input wire logic [ADDR_W-1:0] rxAddr,
  input wire logic autoAckEn,
  // results
  output logic acceptValid,
  output logic [PIPE_IDX_W-1:0] acceptPipe,
  output logic ackReq,
  output logic [ADDR_W-1:0] ackDestAddr,
  output logic discard,
  // configuration readback
  output logic [NUM_PIPES-1:0] pipeEnable,
  output logic [1:0] addrWidth
);
  // ****************************************************************
  // configuration state
  // ****************************************************************
  logic [ADDR_W-1:0] pipe0Addr_q;
  wire [ADDR_W-1:0] pipe0Addr_d;
  logic [ADDR_W-1:0] pipe1Addr_q;
  wire [ADDR_W-1:0] pipe1Addr_d;
  logic [NUM_PIPES-1:0] pipeEn_q;
  wire [NUM_PIPES-1:0] pipeEn_d;
  logic [1:0] width_q;
  wire [1:0] width_d;

  // ****************************************************************
  // result state
  // ****************************************************************
  logic acceptValid_q;
  wire acceptValid_d;
  logic [PIPE_IDX_W-1:0] acceptPipe_q;
  wire [PIPE_IDX_W-1:0] acceptPipe_d;
  logic ackReq_q;
  wire ackReq_d;
  logic [ADDR_W-1:0] ackDest_q;
  wire [ADDR_W-1:0] ackDest_d;
  logic discard_q;
  wire discard_d;

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire wrPipe0 = cfgWrite && (cfgSel == SPAM_WR_PIPE0);
  wire wrPipe1 = cfgWrite && (cfgSel == SPAM_WR_PIPE1);
  wire wrEnable = cfgWrite && (cfgSel == SPAM_WR_ENABLE);
  // code zero names no width, so the write is dropped
  wire widthCodeOk = (cfgData[1:0] != AW_INVALID);
  wire wrWidth = cfgWrite && (cfgSel == SPAM_WR_WIDTH) && widthCodeOk;
  // pipes 0 and 1 own full addresses; only the others have a low-byte register
  wire lowPipeOk = (cfgPipe >= PIPE_IDX_W'(FIRST_LOW_PIPE)) && (cfgPipe < PIPE_IDX_W'(NUM_PIPES));
  wire wrLow = cfgWrite && (cfgSel == SPAM_WR_LOWBYTE) && lowPipeOk;

  // ****************************************************************
  // next configuration values
  // ****************************************************************
  assign pipe0Addr_d = wrPipe0 ? cfgData : pipe0Addr_q;
  assign pipe1Addr_d = wrPipe1 ? cfgData : pipe1Addr_q;
  assign pipeEn_d = wrEnable ? cfgData[NUM_PIPES-1:0] : pipeEn_q;
  assign width_d = wrWidth ? cfgData[1:0] : width_q;

  // ****************************************************************
  // per-pipe low bytes
  // ****************************************************************
  wire [NUM_PIPES*BYTE_W-1:0] lowByteView;
  assign lowByteView[BYTE_W-1:0] = pipe0Addr_q[BYTE_W-1:0];
  assign lowByteView[2*BYTE_W-1:BYTE_W] = pipe1Addr_q[BYTE_W-1:0];

  genvar gi;
  generate
    for (gi = FIRST_LOW_PIPE; gi < NUM_PIPES; gi = gi + 1) begin : g_low
      logic [BYTE_W-1:0] lowByte_q;
      wire wrThis = wrLow && (cfgPipe == PIPE_IDX_W'(gi));
      wire [BYTE_W-1:0] lowByte_d = wrThis ? cfgData[BYTE_W-1:0] : lowByte_q;
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          lowByte_q <= LOW_BYTE_BASE + BYTE_W'(gi);
        end else begin
          lowByte_q <= lowByte_d;
        end
      end
      assign lowByteView[gi*BYTE_W +: BYTE_W] = lowByte_q;
    end
  endgenerate

  // ****************************************************************
  // matcher
  // ****************************************************************
  spam_match_if mif ();
  assign mif.rxAddr = rxAddr;
  assign mif.addrWidth = width_q;
  assign mif.pipe0Addr = pipe0Addr_q;
  assign mif.pipe1Addr = pipe1Addr_q;
  assign mif.lowBytes = lowByteView;
  assign mif.pipeEn = pipeEn_q;

  spam_comparator u_cmp (
    .mif(mif)
  );

  // ****************************************************************
  // receive verdict
  // ****************************************************************
  // a header without a good payload is ignored outright
  wire takeRx = rxValid && rxPayloadOk;
  wire goodRx = takeRx && mif.hit;
  wire badRx = takeRx && !mif.hit;
  wire ackNow = goodRx && autoAckEn;

  assign acceptValid_d = goodRx;
  assign ackReq_d = ackNow;
  assign discard_d = badRx;
  // pipe and sender address hold until the next accepted packet
  assign acceptPipe_d = goodRx ? mif.hitPipe : acceptPipe_q;
  assign ackDest_d = goodRx ? rxAddr : ackDest_q;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pipe0Addr_q <= PIPE0_ADDR_RESET;
    end else begin
      pipe0Addr_q <= pipe0Addr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pipe1Addr_q <= PIPE1_ADDR_RESET;
    end else begin
      pipe1Addr_q <= pipe1Addr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pipeEn_q <= PIPE_EN_RESET;
    end else begin
      pipeEn_q <= pipeEn_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      width_q <= AW_RESET;
    end else begin
      width_q <= width_d;
    end
  end

  // ****************************************************************
  // result registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acceptValid_q <= 1'b0;
    end else begin
      acceptValid_q <= acceptValid_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackReq_q <= 1'b0;
    end else begin
      ackReq_q <= ackReq_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= discard_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acceptPipe_q <= PIPE_NONE;
    end else begin
      acceptPipe_q <= acceptPipe_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ackDest_q <= '0;
    end else begin
      ackDest_q <= ackDest_d;
    end
  end

  // ****************************************************************
  // outputs, straight from flip-flops
  // ****************************************************************
  assign acceptValid = acceptValid_q;
  assign acceptPipe = acceptPipe_q;
  assign ackReq = ackReq_q;
  assign ackDestAddr = ackDest_q;
  assign discard = discard_q;
  assign pipeEnable = pipeEn_q;
  assign addrWidth = width_q;
endmodule

// File: dv/spam_address_match_sva.sv
`timescale 1ns/100ps
module spam_address_match_sva
  import spam_pkg::*;
(
  // clock, reset, configuration
  input logic clk,
  input logic rst_b,
  input logic cfgWrite,
  input spam_wr_t cfgSel,
  input logic [ADDR_W-1:0] cfgData,
  // receive
  input logic rxValid,
  input logic rxPayloadOk,
  input logic [ADDR_W-1:0] rxAddr,
  input logic autoAckEn,
  // results
  input logic acceptValid,
  input logic [2:0] acceptPipe,
  input logic ackReq,
  input logic [ADDR_W-1:0] ackDestAddr,
  input logic discard,
  input logic [5:0] pipeEnable,
  input logic [1:0] addrWidth
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_rx;
    rxValid && rxPayloadOk;
  endsequence
  property p_rst; !$past(rst_b) |-> pipeEnable == PIPE_EN_RESET && addrWidth == AW_RESET; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_en; cfgWrite && cfgSel == SPAM_WR_ENABLE |=> pipeEnable == 6'($past(cfgData)); endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_wid; cfgWrite && cfgSel == SPAM_WR_WIDTH && cfgData[1:0] != 2'h0 |=> addrWidth == 2'($past(cfgData)); endproperty
  a_wid: assert property (p_wid) else $error("width");
  property p_one; s_rx |=> acceptValid != discard; endproperty
  a_one: assert property (p_one) else $error("verdict");
  property p_quiet; !(rxValid && rxPayloadOk) |=> !(acceptValid || discard || ackReq); endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_ack; s_rx ##1 acceptValid |-> ackReq == $past(autoAckEn); endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_dest; acceptValid |-> ackDestAddr == $past(rxAddr) && acceptPipe < 3'h6; endproperty
  a_dest: assert property (p_dest) else $error("dest");
  property p_hold; $past(rst_b) && !acceptValid |-> $stable(acceptPipe) && $stable(ackDestAddr); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule
bind spam_address_match spam_address_match_sva chk (
  .clk(clk),
  .rst_b(rst_b),
  .cfgWrite(cfgWrite),
  .cfgSel(cfgSel),
  .cfgData(cfgData),
  .rxValid(rxValid),
  .rxPayloadOk(rxPayloadOk),
  .rxAddr(rxAddr),
  .autoAckEn(autoAckEn),
  .acceptValid(acceptValid),
  .acceptPipe(acceptPipe),
  .ackReq(ackReq),
  .ackDestAddr(ackDestAddr),
  .discard(discard),
  .pipeEnable(pipeEnable),
  .addrWidth(addrWidth)
);

// File: dv/spam_ptx_model.sv
`timescale 1ns/100ps
module spam_primary_transmitter_model
  import spam_pkg::*;
(
  // clock
  input logic clk,
  // frame toward receiver
  output logic rxValid = 1'b0,
  output logic rxPayloadOk = 1'b0,
  output logic [ADDR_W-1:0] rxAddr = '0
);
  // dest drives rxAddr for one clock cycle; idle address is its bitwise inverse
  task automatic send(input logic [ADDR_W-1:0] dest, input logic crcOk);
    @(negedge clk);
    rxValid = 1'b1;
    rxPayloadOk = crcOk;
    rxAddr = dest;
    @(negedge clk);
    rxValid = 1'b0;
    rxPayloadOk = 1'b0;
    rxAddr = ~dest;
  endtask
endmodule

// File: dv/spam_address_match_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errCount++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module spam_address_match_tb
  import spam_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, cfgWrite = 1'b0, autoAckEn = 1'b1;
  spam_wr_t cfgSel = SPAM_WR_NONE;
  logic [2:0] cfgPipe = 3'h0;
  logic [39:0] cfgData = 40'h0;
  logic rxValid, rxPayloadOk, acceptValid, ackReq, discard;
  logic [39:0] rxAddr, ackDestAddr;
  logic [2:0] acceptPipe;
  logic [5:0] pipeEnable;
  logic [1:0] addrWidth;
  int errCount = 0, comparisons = 0, cycles = 0;
  localparam logic [39:0] P0 = 40'h11_2233_4455;
  localparam logic [39:0] P1 = 40'hA0_B0C0_D010;
  spam_address_match uut (
    .clk(clk),
    .rst_b(rst_b),
    .cfgWrite(cfgWrite),
    .cfgSel(cfgSel),
    .cfgPipe(cfgPipe),
    .cfgData(cfgData),
    .rxValid(rxValid),
    .rxPayloadOk(rxPayloadOk),
    .rxAddr(rxAddr),
    .autoAckEn(autoAckEn),
    .acceptValid(acceptValid),
    .acceptPipe(acceptPipe),
    .ackReq(ackReq),
    .ackDestAddr(ackDestAddr),
    .discard(discard),
    .pipeEnable(pipeEnable),
    .addrWidth(addrWidth)
  );
  spam_primary_transmitter_model txModel (
    .clk(clk),
    .rxValid(rxValid),
    .rxPayloadOk(rxPayloadOk),
    .rxAddr(rxAddr)
  );
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errCount++;
      stopTest();
    end
  end
  function automatic logic [39:0] addrOf(input int p);
    return p == 0 ? P0 : p == 1 ? P1 : {P1[39:8], 8'h20 + 8'(p)};
  endfunction
  task automatic cfg(input spam_wr_t s, input logic [2:0] p, input logic [39:0] d);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgSel = s;
    cfgPipe = p;
    cfgData = d;
    @(negedge clk);
    cfgWrite = 1'b0;
  endtask
  task automatic rx(input logic [39:0] a, input logic ok, input logic [2:0] p, input logic acc);
    txModel.send(a, ok);
    `CHK(acceptValid, acc)
    `CHK(discard, ok & !acc)
    `CHK(ackReq, acc & autoAckEn)
    if (acc) `CHK({acceptPipe, ackDestAddr}, {p, a})
  endtask
  task stopTest;
    $display("errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tReset;
    @(negedge clk);
    rst_b = 1'b0;
    autoAckEn = 1'b1;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    `CHK({pipeEnable, addrWidth, acceptPipe}, {PIPE_EN_RESET, AW_RESET, PIPE_NONE})
    rx({PIPE1_ADDR_RESET[39:8], LOW_BYTE_BASE + 8'h02}, 1'b1, 3'h0, 1'b0);
    rx(PIPE1_ADDR_RESET, 1'b1, 3'h1, 1'b1);
  endtask
  task tPipes;
    cfg(SPAM_WR_ENABLE, 3'h0, 40'h3F);
    cfg(SPAM_WR_PIPE0, 3'h0, P0);
    cfg(SPAM_WR_PIPE1, 3'h0, P1);
    cfg(SPAM_WR_LOWBYTE, 3'h1, 40'h77);
    for (int p = 2; p < 6; p++) cfg(SPAM_WR_LOWBYTE, 3'(p), addrOf(p));
    for (int p = 0; p < 6; p++) rx(addrOf(p), 1'b1, 3'(p), 1'b1);
  endtask
  task tWidth;
    cfg(SPAM_WR_WIDTH, 3'h0, 40'(AW_3BYTE));
    cfg(SPAM_WR_WIDTH, 3'h0, 40'h0);
    `CHK(addrWidth, AW_3BYTE)
    rx({16'h0, P1[23:8], 8'h24}, 1'b1, 3'h4, 1'b1);
    cfg(SPAM_WR_WIDTH, 3'h0, 40'(AW_4BYTE));
    rx({16'h0, P1[23:8], 8'h24}, 1'b1, 3'h0, 1'b0);
  endtask
  task tDrop;
    cfg(SPAM_WR_ENABLE, 3'h0, 40'h37);
    rx(addrOf(3), 1'b1, 3'h0, 1'b0);
    rx(addrOf(2), 1'b0, 3'h0, 1'b0);
    autoAckEn = 1'b0;
    rx(addrOf(5), 1'b1, 3'h5, 1'b1);
  endtask
  initial begin
    tReset();
    tPipes();
    tWidth();
    tDrop();
    tReset();
    stopTest();
  end
endmodule
